// ---- hw/drrc_pkg.sv ----
package drrc_pkg;
    // clock and refresh timing
    localparam int CLK_PERIOD_NS   = 50;
    localparam int REFI_NORM_NS    = 7800;   // 7.8 us below 85 C
    localparam int REFI_EXT_NS     = 3900;   // 3.9 us at or above 85 C
    // longest times round down
    localparam int REFI_NORM_CYC   = REFI_NORM_NS / CLK_PERIOD_NS;
    localparam int REFI_EXT_CYC    = REFI_EXT_NS / CLK_PERIOD_NS;

    // refresh rate mode field codes
    localparam logic [2:0] MODE_FIX1X  = 3'h0;
    localparam logic [2:0] MODE_FIX2X  = 3'h1;
    localparam logic [2:0] MODE_FIX4X  = 3'h2;
    localparam logic [2:0] MODE_OTF12  = 3'h5;
    localparam logic [2:0] MODE_OTF14  = 3'h6;
    localparam int         MODE_LSB    = 6;     // field sits at address bits 8:6
    localparam int         MODE_MSB    = 8;
    // temperature-controlled refresh bits in mode register 4
    localparam int         TCR_EN_BIT  = 2;
    localparam int         TCR_EXT_BIT = 3;
    // mode register select on {bg0, ba1, ba0}
    localparam logic [2:0] MRSEL_RATE  = 3'h3;
    localparam logic [2:0] MRSEL_TCR   = 3'h4;

    // internal rate encodings
    typedef enum logic [1:0] {RATE_1X, RATE_2X, RATE_4X} drrc_rate_t;

    // controller register offsets
    localparam logic [7:0] REG_MODE    = 8'h00;
    localparam logic [7:0] REG_CTRL    = 8'h04;
    localparam logic [7:0] REG_REFCMD  = 8'h08;
    localparam logic [7:0] REG_STATUS  = 8'h0C;
    // field positions
    localparam int F_TCR_EN   = 3;
    localparam int F_TCR_EXT  = 4;
    localparam int F_AUTO_EN  = 0;
    localparam int F_HOT      = 1;
    localparam int F_AUTO_HI  = 2;
    localparam int F_BUSY     = 0;
    localparam int F_DBL_ODD  = 1;
    localparam int F_CNT_LSB  = 8;
    localparam int F_CNT_MSB  = 15;
endpackage : drrc_pkg

// ---- hw/drrc_if.sv ----
`timescale 1ns/1ns
interface drrc_if;
    logic        cs_n;    // chip select, active low
    logic        act_n;   // activate, active low
    logic        ras_n;   // row strobe, active low
    logic        cas_n;   // column strobe, active low
    logic        we_n;    // write enable, active low
    logic [1:0]  bg;      // bank group
    logic [1:0]  ba;      // bank address
    logic [13:0] addr;    // address bus
    // controller drives every pin
    modport ctrl (output cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr);
    // memory device samples every pin
    modport dram (input cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr);
endinterface : drrc_if

// ---- hw/drrc_gear.sv ----
`timescale 1ns/1ns
module drrc_gear
    import drrc_pkg::*;
#(
    parameter int CNT_W = 2
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    // refresh stream
    input  wire logic             ref_in,    // one external refresh taken
    input  wire logic [1:0]       shift,     // log2 of gear ratio
    output logic                  exec_ff,   // internal refresh done
    output logic                  skip_ff    // refresh swallowed
);
    if (CNT_W < 2) begin : g_chk
        $error("drrc_gear: CNT_W must reach a ratio of four");
    end

    logic [CNT_W-1:0] cnt_ff;   // external refresh tally

    // mask of low counter bits that must be zero to execute
    function automatic logic [CNT_W-1:0] gear_mask(input logic [1:0] s);
        gear_mask = CNT_W'((1 << s) - 1);
    endfunction : gear_mask

    // every refresh is registered; only one in 2**shift is executed
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff  <= '0;
            exec_ff <= 1'b0;
            skip_ff <= 1'b0;
        end else if (ce) begin
            exec_ff <= ref_in && ((cnt_ff & gear_mask(shift)) == '0);  // R2
            skip_ff <= ref_in && ((cnt_ff & gear_mask(shift)) != '0);  // R2
            if (ref_in) begin
                cnt_ff <= cnt_ff + CNT_W'(1);
            end
        end
    end
endmodule : drrc_gear

// ---- hw/drrc_device.sv ----
// Operation
// R1: controller refreshes each 7.8us, 3.9us when hot
// R2: device skips refreshes at gear ratio under tcr
// R3: controller picks range matching real temperature
// R4: normal range keeps case at most 85C
// R5: below 45C device may stretch past 7.8us
// R6: extended range, device skips back to 7.8us
// R7: device adjusts interval without controller help
// R8: extended range forbids 7.8us external period
// R9: refresh timing set by mode register field
// R10: on-the-fly mode programmed before such refreshes
// R11: decode mode codes 000,001,010,101,110; others reserved
// R12: on-the-fly refresh samples bg0 for rate
// R13: refresh is cs low act high ras cas low
// R14: even double-rate refreshes between normal ones
// R15: tcr only with mode field 000
// R16: controller never programs reserved mode codes
`timescale 1ns/1ns
module drrc_device
    import drrc_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    // command pins
    drrc_if.dram            pins,
    // temperature sensor, asynchronous levels
    input  wire logic       tc_lt45_async,
    input  wire logic       tc_lt85_async,
    // user side status
    output logic [2:0]      rate_mode_ff,
    output logic            tcr_en_ff,
    output logic            tcr_ext_ff,
    output drrc_rate_t      cur_rate_ff,
    output logic            ref_exec_ff,
    output logic            ref_skip_ff,
    output logic            ref_seen_ff
);
    // temperature synchronisers
    logic       lt45_s1_ff;     // first stage, read only by second
    logic       lt45_ff;        // stable below-45 level
    logic       lt85_s1_ff;     // first stage, read only by second
    logic       lt85_ff;        // stable below-85 level

    // command decode
    logic       is_cmd;         // chip selected, not activate
    logic       is_ref;         // refresh command
    logic       is_mrs;         // mode register write
    logic [2:0] mr_sel;         // addressed mode register
    logic [1:0] nxt_shift;      // gear exponent for this refresh
    drrc_rate_t nxt_rate;       // rate used by this refresh

    // sensor levels come from another domain: two flops first
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lt45_s1_ff <= 1'b0;
            lt45_ff    <= 1'b0;
            lt85_s1_ff <= 1'b0;
            lt85_ff    <= 1'b0;
        end else if (ce) begin
            lt45_s1_ff <= tc_lt45_async;
            lt45_ff    <= lt45_s1_ff;
            lt85_s1_ff <= tc_lt85_async;
            lt85_ff    <= lt85_s1_ff;
        end
    end

    // pins come from controller logic on this clock, no sync needed
    always_comb begin
        is_cmd = !pins.cs_n && pins.act_n;
        is_ref = is_cmd && !pins.ras_n && !pins.cas_n && pins.we_n;    // R13
        is_mrs = is_cmd && !pins.ras_n && !pins.cas_n && !pins.we_n;
        mr_sel = {pins.bg[0], pins.ba};
    end

    // mode register writes: rate field and tcr controls
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rate_mode_ff <= MODE_FIX1X;
            tcr_en_ff    <= 1'b0;
            tcr_ext_ff   <= 1'b0;
        end else if (ce && is_mrs) begin
            if (mr_sel == MRSEL_RATE) begin
                rate_mode_ff <= pins.addr[MODE_MSB:MODE_LSB];           // R9
            end else if (mr_sel == MRSEL_TCR) begin
                tcr_en_ff  <= pins.addr[TCR_EN_BIT];
                tcr_ext_ff <= pins.addr[TCR_EXT_BIT];
            end
        end
    end

    // rate of the refresh now on the pins
    always_comb begin
        case (rate_mode_ff)                                             // R11
            MODE_FIX2X: nxt_rate = RATE_2X;
            MODE_FIX4X: nxt_rate = RATE_4X;
            MODE_OTF12: nxt_rate = pins.bg[0] ? RATE_2X : RATE_1X;    // R12
            MODE_OTF14: nxt_rate = pins.bg[0] ? RATE_4X : RATE_1X;    // R12
            // reserved codes fall back to 1x; behaviour is undefined anyway
            default:    nxt_rate = RATE_1X;
        endcase
    end

    // gear exponent from range and temperature, no controller input
    always_comb begin
        nxt_shift = 2'h0;                                               // R7
        if (tcr_en_ff) begin
            if (!tcr_ext_ff) begin
                // normal range: stretch only when cool
                nxt_shift = lt45_ff ? 2'h1 : 2'h0;                      // R5
            end else if (lt85_ff) begin
                // extended range feeds 3.9us: halve back, quarter if cool
                nxt_shift = lt45_ff ? 2'h2 : 2'h1;                      // R6
            end
        end
    end

    // rate switches on the same edge that registers the refresh,
    // so it is already in force when the execute pulse shows
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur_rate_ff <= RATE_1X;
            ref_seen_ff <= 1'b0;
        end else if (ce) begin
            ref_seen_ff <= is_ref;                                      // R2
            if (is_ref) begin
                cur_rate_ff <= nxt_rate;                                // R12
            end
        end
    end

    // gear keeps the skip tally
    drrc_gear #(
        .CNT_W   (2)
    ) u_gear (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .ce      (ce),
        .ref_in  (is_ref),
        .shift   (nxt_shift),
        .exec_ff (ref_exec_ff),
        .skip_ff (ref_skip_ff)
    );
endmodule : drrc_device

// ---- hw/drrc_ctrl.sv ----
`timescale 1ns/1ns
module drrc_ctrl
    import drrc_pkg::*;
#(
    parameter int TMR_W = 8     // refresh timer width
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata_ff,
    output logic             pready_ff,
    output logic             pslverr_ff,
    // command pins
    drrc_if.ctrl             pins
);
    if ((1 << TMR_W) <= REFI_NORM_CYC) begin : g_chk
        $error("drrc_ctrl: TMR_W too small for refresh interval");
    end

    typedef enum {ST_IDLE, ST_MRATE, ST_MTCR, ST_REF} drrc_st_t;

    drrc_st_t   st_ff;          // command sequencer
    logic [4:0] mode_ff;        // tcr_ext, tcr_en, rate field
    logic [2:0] ctrl_ff;        // auto_hi, hot, auto_en
    logic       mrs_pend_ff;    // mode writes waiting
    logic       ref_pend_ff;    // refresh waiting
    logic       ref_bg_ff;      // bg0 for waiting refresh
    logic       dbl_odd_ff;     // odd double-rate refreshes so far
    logic [7:0] ref_cnt_ff;     // issued refreshes, wraps
    logic [TMR_W-1:0] tmr_ff;   // cycles to next auto refresh
    logic       acc;            // first access cycle
    logic       done;           // completing edge of an accepted transfer
    logic       busy;           // sequencer or a request pending
    logic       bad;            // refusal of this access
    logic       tmr_hit;        // auto refresh due
    logic       auto_bg;        // bg0 for auto refreshes
    logic [TMR_W-1:0] nxt_reload;

    // reserved code or tcr with a non-1x mode is refused
    function automatic logic mode_ok(input logic [4:0] m);
        logic legal;
        legal = (m[2:0] == MODE_FIX1X) || (m[2:0] == MODE_FIX2X) ||
                (m[2:0] == MODE_FIX4X) || (m[2:0] == MODE_OTF12) ||
                (m[2:0] == MODE_OTF14);                                 // R16
        mode_ok = legal && !(m[F_TCR_EN] && (m[2:0] != MODE_FIX1X));    // R15
    endfunction : mode_ok

    always_comb begin
        acc  = psel && penable && !pready_ff;
        done = psel && penable && pready_ff && !pslverr_ff;
        busy = (st_ff != ST_IDLE) || mrs_pend_ff || ref_pend_ff;
        // hot case or extended range both need the short period
        nxt_reload = (ctrl_ff[F_HOT] || mode_ff[F_TCR_EXT]) ?           // R1 R8
                     TMR_W'(REFI_EXT_CYC - 1) : TMR_W'(REFI_NORM_CYC - 1); // R4
        tmr_hit = ctrl_ff[F_AUTO_EN] && (tmr_ff == '0);
        // keep double-rate refreshes paired in the 1x/2x mode
        auto_bg = ctrl_ff[F_AUTO_HI] || dbl_odd_ff;                     // R14
        bad = 1'b0;
        if (paddr == REG_MODE) begin
            bad = pwrite && (busy || !mode_ok(pwdata[4:0]));
        end else if (paddr == REG_CTRL) begin
            bad = 1'b0;
        end else if (paddr == REG_REFCMD) begin
            bad = !pwrite || busy ||
                  (pwdata[0] && mode_ff[2:0] != MODE_OTF12 &&
                   mode_ff[2:0] != MODE_OTF14) ||                       // R10
                  (!pwdata[0] && dbl_odd_ff);                           // R14
        end else if (paddr == REG_STATUS) begin
            bad = pwrite;
        end else begin
            bad = 1'b1;
        end
    end

    // apb answer: one wait cycle, read data and error with pready
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else if (ce) begin
            pready_ff  <= acc;
            pslverr_ff <= acc && bad;
            if (acc && !pwrite) begin
                prdata_ff <= 32'h0000_0000;
                if (paddr == REG_MODE) begin
                    prdata_ff[4:0] <= mode_ff;
                end else if (paddr == REG_CTRL) begin
                    prdata_ff[2:0] <= ctrl_ff;
                end else if (paddr == REG_STATUS) begin
                    prdata_ff[F_BUSY]             <= busy;
                    prdata_ff[F_DBL_ODD]          <= dbl_odd_ff;
                    prdata_ff[F_CNT_MSB:F_CNT_LSB] <= ref_cnt_ff;
                end
            end
        end
    end

    // register writes take effect at the completing edge only
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode_ff <= 5'h00;
            ctrl_ff <= 3'h0;
        end else if (ce && done && pwrite) begin
            if (paddr == REG_MODE) begin
                mode_ff <= pwdata[4:0];                                 // R3
            end else if (paddr == REG_CTRL) begin
                ctrl_ff <= pwdata[2:0];
            end
        end
    end

    // auto refresh timer, restarts from the period each time it hits
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tmr_ff <= TMR_W'(REFI_NORM_CYC - 1);
        end else if (ce) begin
            if (!ctrl_ff[F_AUTO_EN] || tmr_hit) begin
                tmr_ff <= nxt_reload;                                   // R1
            end else begin
                tmr_ff <= tmr_ff - TMR_W'(1);
            end
        end
    end

    // pending requests; a new set beats the clear of the same edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mrs_pend_ff <= 1'b0;
            ref_pend_ff <= 1'b0;
            ref_bg_ff   <= 1'b0;
        end else if (ce) begin
            if (done && pwrite && paddr == REG_MODE) begin
                mrs_pend_ff <= 1'b1;                                    // R10
            end else if (st_ff == ST_IDLE) begin
                mrs_pend_ff <= 1'b0;
            end
            if (done && pwrite && paddr == REG_REFCMD) begin
                ref_pend_ff <= 1'b1;
                ref_bg_ff   <= pwdata[0];
            end else if (tmr_hit && !ref_pend_ff) begin
                ref_pend_ff <= 1'b1;
                ref_bg_ff   <= auto_bg && (mode_ff[2:0] == MODE_OTF12 ||
                                           mode_ff[2:0] == MODE_OTF14);
            end else if (st_ff == ST_IDLE && !mrs_pend_ff) begin
                ref_pend_ff <= 1'b0;
            end
        end
    end

    // sequencer: each command stands one cycle; the two mode writes run back to back, then deselect
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff      <= ST_IDLE;
            pins.cs_n  <= 1'b1;
            pins.act_n <= 1'b1;
            pins.ras_n <= 1'b1;
            pins.cas_n <= 1'b1;
            pins.we_n  <= 1'b1;
            pins.bg    <= 2'h0;
            pins.ba    <= 2'h0;
            pins.addr  <= 14'h0000;
            dbl_odd_ff <= 1'b0;
            ref_cnt_ff <= 8'h00;
        end else if (ce) begin
            pins.cs_n  <= 1'b1;
            pins.ras_n <= 1'b1;
            pins.cas_n <= 1'b1;
            pins.we_n  <= 1'b1;
            pins.addr  <= 14'h0000;
            case (st_ff)
                ST_IDLE: begin
                    // rate field goes first so it is set before any refresh
                    if (mrs_pend_ff) begin
                        st_ff     <= ST_MRATE;
                        pins.cs_n <= 1'b0;
                        pins.ras_n <= 1'b0;
                        pins.cas_n <= 1'b0;
                        pins.we_n <= 1'b0;
                        {pins.bg[0], pins.ba} <= MRSEL_RATE;
                        pins.addr[MODE_MSB:MODE_LSB] <= mode_ff[2:0];   // R11
                        dbl_odd_ff <= 1'b0;
                    end else if (ref_pend_ff) begin
                        st_ff      <= ST_REF;
                        pins.cs_n  <= 1'b0;                             // R13
                        pins.ras_n <= 1'b0;
                        pins.cas_n <= 1'b0;
                        pins.bg[0] <= ref_bg_ff;                        // R12
                        ref_cnt_ff <= ref_cnt_ff + 8'h01;
                        if (mode_ff[2:0] == MODE_OTF12) begin
                            dbl_odd_ff <= ref_bg_ff ? !dbl_odd_ff : 1'b0; // R14
                        end
                    end
                end
                ST_MRATE: begin
                    st_ff      <= ST_MTCR;
                    pins.cs_n  <= 1'b0;
                    pins.ras_n <= 1'b0;
                    pins.cas_n <= 1'b0;
                    pins.we_n  <= 1'b0;
                    {pins.bg[0], pins.ba} <= MRSEL_TCR;
                    pins.addr[TCR_EN_BIT]  <= mode_ff[F_TCR_EN];
                    pins.addr[TCR_EXT_BIT] <= mode_ff[F_TCR_EXT];
                end
                default: begin
                    st_ff <= ST_IDLE;
                end
            endcase
        end
    end
endmodule : drrc_ctrl

// ---- test/drrc_props.sv ----
`timescale 1ns/1ns
module drrc_props
    import drrc_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rstn,
    // command pins
    input wire logic        cs_n,
    input wire logic        act_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [1:0]  bg,
    input wire logic [1:0]  ba,
    input wire logic [13:0] addr,
    // device status
    input wire logic [2:0]  rate_mode_ff,
    input wire logic        tcr_en_ff,
    input wire drrc_rate_t  cur_rate_ff,
    input wire logic        ref_seen_ff,
    input wire logic        ref_exec_ff,
    input wire logic        ref_skip_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // refresh and mode write patterns on the pins
    sequence s_ref;
        !cs_n && act_n && !ras_n && !cas_n && we_n;
    endsequence
    sequence s_mrs(logic [2:0] sel);
        !cs_n && act_n && !ras_n && !cas_n && !we_n && {bg[0], ba} == sel;
    endsequence
    // a refresh is a single-cycle pulse
    ref_pulse_a: assert property (s_ref |=> cs_n)
        else $error("refresh command held too long");
    // deselect keeps every strobe inactive
    idle_pins_a: assert property (cs_n |-> act_n && ras_n && cas_n && we_n)
        else $error("strobe active while deselected");
    // device takes every refresh seen on the pins
    ref_taken_a: assert property (s_ref |=> ref_seen_ff)
        else $error("refresh not taken");
    // each taken refresh is either run or skipped, never both
    exec_or_skip_a: assert property (ref_seen_ff |-> ref_exec_ff ^ ref_skip_ff)
        else $error("refresh neither or both run and skipped");
    // without temperature control nothing is skipped
    no_tcr_skip_a: assert property (ref_seen_ff && !$past(tcr_en_ff) |-> ref_exec_ff)
        else $error("refresh skipped with temperature control off");
    // rate field written by a mode write lands in the device
    mode_load_a: assert property (s_mrs(MRSEL_RATE) |=> rate_mode_ff == $past(addr[8:6]))
        else $error("rate field not loaded");
    // both mode writes go back to back, then deselect
    mrs_order_a: assert property (s_mrs(MRSEL_RATE) |=> s_mrs(MRSEL_TCR) ##1 cs_n)
        else $error("mode write order broken");
    // fixed 2x mode runs double rate
    fix2x_rate_a: assert property (s_ref ##0 rate_mode_ff == MODE_FIX2X
        |=> cur_rate_ff == RATE_2X)
        else $error("fixed double rate not applied");
    // on-the-fly: low bank group bit selects 1x
    otf_low_a: assert property (s_ref ##0 rate_mode_ff[2] && !bg[0]
        |=> cur_rate_ff == RATE_1X)
        else $error("on-the-fly normal rate not applied");
    // on-the-fly 1x/4x: high bank group bit selects 4x
    otf_quad_a: assert property (s_ref ##0 rate_mode_ff == MODE_OTF14 && bg[0]
        |=> cur_rate_ff == RATE_4X)
        else $error("on-the-fly quad rate not applied");
endmodule : drrc_props

// ---- test/tb.sv ----
`timescale 1ns/1ns
module tb
    import drrc_pkg::*;
;
    // stimulus and design outputs
    logic        sys_clk, rstn, ce, psel, penable, pwrite, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata_ff, rd;
    logic        pready_ff, pslverr_ff, tc_lt45_async, tc_lt85_async;
    logic [2:0]  rate_mode_ff;
    logic        tcr_en_ff, tcr_ext_ff, ref_exec_ff, ref_skip_ff, ref_seen_ff;
    drrc_rate_t  cur_rate_ff;
    // bench model state
    int          failures, n_tests, n_seen, n_exec, cyc, cur_mode;
    int          t45, t85, temp_controlled_refresh, ext, sh, n0;
    int          codes[5] = '{0, 1, 2, 5, 6};
    int          res[3] = '{3, 4, 7};
    drrc_rate_t  exp_q[$];    // predicted rate per refresh

    drrc_if link ();
    drrc_ctrl drrc_ctrl_inst (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
        .pins(link.ctrl));
    drrc_device drrc_device_inst (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
        .pins(link.dram), .tc_lt45_async(tc_lt45_async), .tc_lt85_async(tc_lt85_async),
        .rate_mode_ff(rate_mode_ff), .tcr_en_ff(tcr_en_ff), .tcr_ext_ff(tcr_ext_ff),
        .cur_rate_ff(cur_rate_ff), .ref_exec_ff(ref_exec_ff), .ref_skip_ff(ref_skip_ff),
        .ref_seen_ff(ref_seen_ff));
    drrc_props drrc_props_inst (.sys_clk(sys_clk), .rstn(rstn), .cs_n(link.cs_n),
        .act_n(link.act_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
        .bg(link.bg), .ba(link.ba), .addr(link.addr), .rate_mode_ff(rate_mode_ff),
        .tcr_en_ff(tcr_en_ff), .cur_rate_ff(cur_rate_ff), .ref_seen_ff(ref_seen_ff),
        .ref_exec_ff(ref_exec_ff), .ref_skip_ff(ref_skip_ff));

    // 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // one apb transfer; waits for pready, no fixed latency assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready_ff !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd = prdata_ff;
        err = pslverr_ff;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    // model of rate chosen for one refresh
    function automatic drrc_rate_t rate_of(input int m, input int b);
        if (m == 1 || (m == 5 && b == 1)) return RATE_2X;
        if (m == 2 || (m == 6 && b == 1)) return RATE_4X;
        return RATE_1X;
    endfunction : rate_of

    // mode write, then device fields compared with the model
    task automatic set_mode(input int v, input int ok);
        apb(1'b1, REG_MODE, 32'(v));
        chk(32'(err), 32'(ok == 0), "mode refusal");
        if (ok != 0) cur_mode = v;
        repeat (3) @(posedge sys_clk);
        chk(32'(rate_mode_ff), 32'(cur_mode & 7), "rate field");
        chk(32'(tcr_en_ff), 32'((cur_mode >> 3) & 1), "tcr enable");
        chk(32'(tcr_ext_ff), 32'((cur_mode >> 4) & 1), "tcr range");
    endtask : set_mode

    // queue one refresh; accepted ones must reach the device once
    task automatic do_ref(input int m, input int b, input int ok);
        int s0;
        int k;
        s0 = n_seen;
        k = 0;
        apb(1'b1, REG_REFCMD, 32'(b));
        chk(32'(err), 32'(ok == 0), "refresh refusal");
        if (ok != 0) exp_q.push_back(rate_of(m, b));
        while (ok != 0 && n_seen == s0 && k < 20) begin
            @(posedge sys_clk);
            k++;
        end
        if (ok != 0) chk(32'(n_seen - s0), 32'h1, "refresh count");
        @(posedge sys_clk);
    endtask : do_ref

    // scoreboard and hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 20000) begin
            failures++;
            end_of_test();
        end
        if (ref_seen_ff === 1'b1) begin
            n_seen++;
            if (ref_exec_ff === 1'b1) n_exec++;
            if (exp_q.size() == 0) chk(32'h1, 32'h0, "unexpected refresh");
            else chk(32'(cur_rate_ff), 32'(exp_q.pop_front()), "refresh rate");
        end
    end

    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        {ce, tc_lt45_async, tc_lt85_async} = 3'h7;
        void'($urandom(32'h057D));
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        // reset values, write-only and unmapped reads
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(32'(err), 32'(i == 2 || i == 4), "read refusal");
            if (err === 1'b0) chk(rd, 32'h0, "reset value");
        end
        apb(1'b1, REG_STATUS, 32'h0);
        chk(32'(err), 32'h1, "status write");
        // every legal rate mode, both bank group values
        foreach (codes[i]) begin
            if (codes[i] != 0) set_mode(codes[i] + 8, 0);
            set_mode(codes[i], 1);
            do_ref(codes[i], 0, 1);
            do_ref(codes[i], 1, int'(codes[i] > 4));
            if (codes[i] > 4) begin
                do_ref(codes[i], 0, int'(codes[i] != 5));
                do_ref(codes[i], 1, 1);
                do_ref(codes[i], 0, 1);
            end
        end
        foreach (res[i]) set_mode(res[i], 0);
        // hot auto refresh: short period, three fit in the window
        repeat (3) exp_q.push_back(RATE_1X);
        apb(1'b1, REG_CTRL, 32'h2);
        n0 = n_seen;
        apb(1'b1, REG_CTRL, 32'h3);
        repeat (4 * REFI_EXT_CYC - 20) @(posedge sys_clk);
        apb(1'b1, REG_CTRL, 32'h0);
        chk(32'(n_seen - n0), 32'h3, "auto refreshes");
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'(n_seen % 256) << 8, "status count");
        // random temperature and range: executed share follows the gear
        for (int it = 0; it < 8; it++) begin
            t45 = $urandom % 2;
            t85 = t45 | ($urandom % 2);
            temp_controlled_refresh = $urandom % 2;
            ext = $urandom % 2;
            tc_lt45_async <= 1'(t45);
            tc_lt85_async <= 1'(t85);
            set_mode(temp_controlled_refresh * 8 + ext * 16, 1);
            sh = (temp_controlled_refresh == 0) ? 0 : (ext == 0) ? t45 : (t85 == 0) ? 0 : (t45 != 0) ? 2 : 1;
            n0 = n_exec;
            repeat (4) do_ref(0, 0, 1);
            chk(32'(n_exec - n0), 32'(4 >> sh), "executed refreshes");
        end
        end_of_test();
    end
endmodule : tb
